// File: design/lsl_driver.sv
// LED shift register, output latch and blanking, sampled on one system clock
`include "lsl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module lsl_driver
    import lsl_pkg::*;
#(
    parameter int WORD_BITS = `LSL_WORD_BITS
) (
    // System
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Serial link from host
    input  wire logic                 shift_clk_i,
    input  wire logic                 serial_data_i,
    input  wire logic                 load_strobe_i,
    input  wire logic                 blank_n_i,
    output logic                      serial_data_o,
    // Snapshot stream of each shifted word the buffer has room for
    output logic                      word_valid_o,
    output logic [WORD_BITS-1:0]      word_data_o,
    input  wire logic                 word_ready_i,
    // LED sinks, open drain: enable high pulls the sink low
    output logic [WORD_BITS-1:0]      led_sink_o,
    output logic [WORD_BITS-1:0]      led_sink_oe_o
);

    initial begin
        if (WORD_BITS != `LSL_WORD_BITS) begin
            $error("lsl_driver: word must be eight bits");
        end
    end

    // Two-stage synchronisers; first stage read only by second
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] next_sync1;
    logic [3:0] next_sync2;
    logic       clk_prev;
    logic       next_clk_prev;

    always_comb begin
        next_sync1       = {blank_n_i, load_strobe_i, serial_data_i, shift_clk_i};
        next_sync2       = sync1;
        next_clk_prev    = sync2[0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1       <= 4'h0;
            sync2       <= 4'h0;
            clk_prev    <= 1'b0;
        end else begin
            sync1       <= next_sync1;
            sync2       <= next_sync2;
            clk_prev    <= next_clk_prev;
        end
    end

    logic shift_rise;
    logic data_s;
    logic strobe_s;
    logic blank_n_s;
    assign shift_rise = sync2[0] & ~clk_prev;
    assign data_s     = sync2[1];
    assign strobe_s   = sync2[2];
    assign blank_n_s  = sync2[3];

    // Data and clock share sync depth, so data is sampled at its clock edge
    lsl_word_t shift_reg;
    lsl_word_t latch_q;
    lsl_word_t next_shift_reg;
    lsl_word_t next_latch_q;
    logic      ser_out;
    logic      next_ser_out;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic       word_done;

    always_comb begin
        next_shift_reg = shift_reg;
        next_ser_out   = ser_out;
        next_bit_cnt   = bit_cnt;
        word_done      = 1'b0;
        if (shift_rise) begin
            // Output mirrors stage 7 after the shift: eight edges of delay
            next_shift_reg = {shift_reg[WORD_BITS-2:0], data_s};
            next_ser_out   = next_shift_reg[WORD_BITS-1];
            next_bit_cnt   = bit_cnt + 3'h1;
            word_done      = (bit_cnt == 3'h7);
        end
        // Transparent while high, frozen once low; blanking ignored here
        next_latch_q = strobe_s ? next_shift_reg : latch_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_reg <= `LSL_SHIFT_RESET;
            latch_q   <= `LSL_LATCH_RESET;
            ser_out   <= 1'b0;
            bit_cnt   <= 3'h0;
        end else begin
            shift_reg <= next_shift_reg;
            latch_q   <= next_latch_q;
            ser_out   <= next_ser_out;
            bit_cnt   <= next_bit_cnt;
        end
    end

    // Sink drivers: open drain, enable only for a latched one while blank_n_i is low
    lsl_word_t sink_oe;
    lsl_word_t next_sink_oe;
    always_comb begin
        next_sink_oe = blank_n_s ? '0 : next_latch_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sink_oe <= '0;
        end else begin
            sink_oe <= next_sink_oe;
        end
    end

    // Two-entry buffer of completed words; a word completed while both entries are full is dropped
    lsl_word_t buf_mem [`LSL_BUF_DEPTH];
    logic      wr_ptr;
    logic      rd_ptr;
    logic [1:0] count;
    logic      next_wr_ptr;
    logic      next_rd_ptr;
    logic [1:0] next_count;
    logic      buf_full;
    logic      push;
    logic      pop;
    logic      out_valid;
    lsl_word_t out_data;
    logic      next_out_valid;
    lsl_word_t next_out_data;

    assign buf_full = (count == 2'd2);
    // Source cannot be paused, so a word arriving while full is lost
    assign push     = word_done & ~buf_full;
    assign pop      = (count != 2'd0) & (~out_valid | word_ready_i);

    always_comb begin
        next_wr_ptr    = push ? ~wr_ptr : wr_ptr;
        next_rd_ptr    = pop ? ~rd_ptr : rd_ptr;
        next_count     = count + {1'b0, push} - {1'b0, pop};
        next_out_valid = out_valid;
        next_out_data  = out_data;
        if (pop) begin
            next_out_valid = 1'b1;
            next_out_data  = buf_mem[rd_ptr];
        end else if (word_ready_i) begin
            next_out_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            buf_mem[wr_ptr] <= next_shift_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr    <= 1'b0;
            rd_ptr    <= 1'b0;
            count     <= 2'd0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            out_valid <= next_out_valid;
            out_data  <= next_out_data;
        end
    end

    assign serial_data_o = ser_out;
    assign led_sink_oe_o = sink_oe;
    assign led_sink_o    = '0;
    assign word_valid_o  = out_valid;
    assign word_data_o   = out_data;

endmodule

`default_nettype wire

// File: include/lsl_defines.svh
// Constants for the LED shift latch driver
`ifndef LSL_DEFINES_SVH
`define LSL_DEFINES_SVH

`define LSL_WORD_BITS     8
`define LSL_SHIFT_RESET   8'h00
`define LSL_LATCH_RESET   8'h00
`define LSL_BUF_DEPTH     2

`endif

// File: include/lsl_pkg.sv
// Types for the LED shift latch driver
package lsl_pkg;
    typedef logic [7:0] lsl_word_t;
    typedef enum logic [1:0] {
        LSL_EMPTY = 2'b01,
        LSL_HELD  = 2'b10
    } lsl_fill_e;
endpackage

// File: bench/lsl_host.sv
// Host model driving the serial link of the LED driver
`timescale 1ns/1ps
`default_nettype none
module lsl_host (
    output logic sclk_o,
    output logic sdi_o,
    output logic le_o
);
    initial {sclk_o, sdi_o, le_o} = 3'h0;
    task automatic send(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            sdi_o = w[i];
            #62.5 sclk_o = 1'b1;
            #20 sdi_o = ~w[i]; // Hold over, inverted level
            #42.5 sclk_o = 1'b0;
        end
    endtask
    task automatic strobe();
        #50 le_o = 1'b1;
        #100 le_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: bench/lsl_driver_monitor.sv
// Port assertions for the LED shift latch driver
`timescale 1ns/1ps
`default_nettype none
module lsl_driver_monitor #(parameter int WORD_BITS = 8) (
    input wire logic clk_i, rst_i, shift_clk_i, serial_data_i, load_strobe_i,
    input wire logic blank_n_i, serial_data_o, word_valid_o, word_ready_i,
    input wire logic [WORD_BITS-1:0] word_data_o, led_sink_o, led_sink_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence lit_s; (load_strobe_i && !blank_n_i)[*6]; endsequence
    sequence held_s; (!load_strobe_i && !blank_n_i)[*6]; endsequence
    AST_SINK_LEVEL: assert property (led_sink_o == '0)
        else $error("sink level");
    AST_BLANK: assert property (blank_n_i[*6] |-> led_sink_oe_o == '0)
        else $error("blank");
    AST_SDO: assert property ($changed(serial_data_o) |->
        $past(shift_clk_i, 3) && !$past(shift_clk_i, 4)) else $error("sdo");
    AST_HOLD: assert property (held_s |-> $stable(led_sink_oe_o))
        else $error("hold");
    AST_THRU: assert property (lit_s |->
        led_sink_oe_o[WORD_BITS-1] == serial_data_o) else $error("thru");
    AST_VHOLD: assert property (word_valid_o && !word_ready_i |=> word_valid_o)
        else $error("vhold");
    AST_DHOLD: assert property (word_valid_o && !word_ready_i |=>
        $stable(word_data_o)) else $error("dhold");
    AST_DROP: assert property ($fell(word_valid_o) |-> $past(word_ready_i))
        else $error("drop");
endmodule
bind lsl_driver lsl_driver_monitor #(.WORD_BITS(WORD_BITS)) i_mon (.*);
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the LED shift latch driver
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lsl_pkg::*;
    logic clk_i = 0, rst_i = 1, blank_n = 0, ready = 0;
    logic sclk, sdi, le, sdo, valid;
    lsl_word_t data, sink, oe, w, a;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    lsl_host i_host (.sclk_o(sclk), .sdi_o(sdi), .le_o(le));
    lsl_driver i_dut (.clk_i(clk_i), .rst_i(rst_i), .shift_clk_i(sclk),
        .serial_data_i(sdi), .load_strobe_i(le), .blank_n_i(blank_n),
        .serial_data_o(sdo), .word_valid_o(valid), .word_data_o(data),
        .word_ready_i(ready), .led_sink_o(sink), .led_sink_oe_o(oe));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (++cyc == 20000) begin
        n_mismatch++;
        complete_run();
    end
    task automatic check(input lsl_word_t seen, input lsl_word_t exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic take();
        ready = 1;
        tick(1);
        ready = 0;
        tick(2);
    endtask
    task automatic complete_run();
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hbd58e3a9));
        tick(5);
        rst_i = 0;
        for (int i = 0; i < 6; i++) begin
            w = i == 0 ? 8'h80 : i == 1 ? 8'h01 : 8'($urandom);
            blank_n = i[0];
            i_host.send(w);
            i_host.strobe();
            tick(8);
            check(oe, i[0] ? 8'h00 : w);
            check({7'h0, sdo}, {7'h0, w[7]});
            check(data, w);
            take();
            blank_n = 0;
            tick(8);
            check(oe, w);
        end
        // Output stage plus two entries hold three words; the fourth is lost
        a = 8'($urandom);
        i_host.send(a);
        i_host.send(~a);
        i_host.send(a ^ 8'h5a);
        i_host.send(8'h3c);
        tick(8);
        check(oe, w);
        check(data, a);
        take();
        check(data, ~a);
        take();
        check(data, a ^ 8'h5a);
        take();
        check({7'h0, valid}, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
